// File: oas_size_select.sv
// Contract
// - In protected mode outside system management mode, default operand and address size follow code-segment default flag: set 32, clear 16.
// - Real-address and virtual-8086 modes default both sizes to 16 bits.
// - Operand prefix 66h inverts the instruction's default operand size.
// - Address prefix 67h inverts the instruction's default address size.
// - Overrides apply only to the instruction they precede.
// - Operand and address overrides act independently of each other.
// - Every operand/address size combination reachable from any segment default.
// - Both prefixes honoured in real, protected and virtual-8086 modes.
// - Implicit stack references use wide pointer if stack flag set, else narrow.
// - Stack flag governs implicit references only; explicit ones use address size.
// - Stack flag of data descriptor selects expand-down upper bound.
// - Gated transfers take operand size and save format from gate type only.
// - 16-bit address size limits offsets to the first 64 KBytes.
// - Stack-pointer width depends solely on stack flag, whatever the operand size.
`timescale 1ns/10ps
`default_nettype none
`include "oas_defines.svh"

module oas_size_select
    import oas_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    // Instruction hand-over from fetch
    input wire logic insn_valid,
    input wire logic [31:0] insn_word,
    input wire logic pfx_opsize,
    input wire logic pfx_adsize,
    input wire logic via_gate,
    input wire logic gate_is_32,
    input wire logic stack_implicit,
    input wire logic [31:0] raw_offset,
    // Mode and descriptor state
    input wire logic [2:0] cpu_mode,
    input wire logic system_management_mode,
    input wire logic cs_default_32,
    input wire logic ss_big,
    input wire logic ds_big,
    input wire logic ds_expand_down,
    // Datapath handshake
    input wire logic exec_done,
    output logic insn_ready,
    output logic sel_valid,
    output logic [31:0] sel_insn,
    output logic op_size_32,
    output logic addr_size_32,
    output logic save_fmt_32,
    output logic stack_use_wide,
    output logic stack_ptr_wide,
    output logic [31:0] eff_offset,
    output logic [31:0] ds_upper_bound
);

    // ------------------------------------------------------------
    // Default size resolution
    // ------------------------------------------------------------
    wire logic no_descriptors;
    wire logic default_32;
    wire logic op_32_pfx;
    wire logic ad_32_pfx;
    wire logic op_32_final;
    wire logic sp_wide;
    wire logic stack_wide_eff;
    wire logic [31:0] offset_nxt;
    wire logic [31:0] bound_nxt;
    wire logic take;
    wire logic ready_nxt;
    wire logic valid_nxt;
    wire logic [31:0] sel_insn_nxt;
    wire logic op_size_nxt;
    wire logic addr_size_nxt;
    wire logic save_fmt_nxt;
    wire logic stack_use_nxt;
    wire logic stack_ptr_nxt;

    // Native 16-bit modes consult no descriptors
    assign no_descriptors = (cpu_mode == OAS_MODE_REAL) || (cpu_mode == OAS_MODE_V86)
                          || system_management_mode;
    assign default_32 = no_descriptors ? `OAS_SZ16 : cs_default_32;

    // Prefixes flip each default on their own, in every mode
    assign op_32_pfx = default_32 ^ pfx_opsize;
    assign ad_32_pfx = default_32 ^ pfx_adsize;

    // Gate type overrides both default flag and prefix
    assign op_32_final = via_gate ? gate_is_32 : op_32_pfx;

    // ------------------------------------------------------------
    // Stack pointer selection
    // ------------------------------------------------------------
    // Stack pointer width from stack descriptor alone
    assign sp_wide = ss_big;
    assign stack_wide_eff = stack_implicit ? sp_wide : ad_32_pfx;

    // ------------------------------------------------------------
    // Offset limiting and expand-down bound
    // ------------------------------------------------------------
    assign offset_nxt = ad_32_pfx ? raw_offset : (raw_offset & `OAS_OFS16_MASK);
    assign bound_nxt = (ds_expand_down && ds_big) ? `OAS_BOUND32 : `OAS_BOUND16;

    // ------------------------------------------------------------
    // Captured values
    // ------------------------------------------------------------
    assign sel_insn_nxt = insn_word;
    assign op_size_nxt = op_32_final;
    assign addr_size_nxt = ad_32_pfx;
    assign save_fmt_nxt = op_32_final;
    assign stack_use_nxt = stack_wide_eff;
    assign stack_ptr_nxt = sp_wide;

    // ------------------------------------------------------------
    // Per-instruction hold
    // ------------------------------------------------------------
    oas_state_e state_r;
    oas_state_e state_nxt;

    // Only an offer seen while ready is accepted, so none slips in just after reset
    assign take = insn_ready && insn_valid;
    assign ready_nxt = (state_nxt == OAS_ST_IDLE);
    assign valid_nxt = (state_nxt == OAS_ST_HOLD);

    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            OAS_ST_IDLE:
            begin
                // Completion pulses seen while idle are ignored
                if (take)
                begin
                    state_nxt = OAS_ST_HOLD;
                end
            end
            OAS_ST_HOLD:
            begin
                if (exec_done)
                begin
                    state_nxt = OAS_ST_IDLE;
                end
            end
            default:
            begin
                state_nxt = OAS_ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_r <= OAS_ST_IDLE;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // ------------------------------------------------------------
    // Handshake outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            insn_ready <= 1'h0;
        end
        else
        begin
            insn_ready <= ready_nxt;
        end
    end

    // Valid marks the whole execution window of the held instruction
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sel_valid <= 1'h0;
        end
        else
        begin
            sel_valid <= valid_nxt;
        end
    end

    // ------------------------------------------------------------
    // Captured instruction
    // ------------------------------------------------------------
    // Results latched per instruction, so prefixes never leak forward
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sel_insn <= 32'h0;
        end
        else if (take)
        begin
            sel_insn <= sel_insn_nxt;
        end
    end

    // ------------------------------------------------------------
    // Size outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            op_size_32 <= `OAS_SZ16;
        end
        else if (take)
        begin
            op_size_32 <= op_size_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            addr_size_32 <= `OAS_SZ16;
        end
        else if (take)
        begin
            addr_size_32 <= addr_size_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            save_fmt_32 <= `OAS_SZ16;
        end
        else if (take)
        begin
            save_fmt_32 <= save_fmt_nxt;
        end
    end

    // ------------------------------------------------------------
    // Stack outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stack_use_wide <= `OAS_SZ16;
        end
        else if (take)
        begin
            stack_use_wide <= stack_use_nxt;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stack_ptr_wide <= `OAS_SZ16;
        end
        else if (take)
        begin
            stack_ptr_wide <= stack_ptr_nxt;
        end
    end

    // ------------------------------------------------------------
    // Offset and bound outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            eff_offset <= 32'h0;
        end
        else if (take)
        begin
            eff_offset <= offset_nxt;
        end
    end

    // Bound tracks the descriptor inputs every cycle, not per instruction
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ds_upper_bound <= `OAS_BOUND16;
        end
        else
        begin
            ds_upper_bound <= bound_nxt;
        end
    end

endmodule
`default_nettype wire

// File: oas_defines.svh
`ifndef OAS_DEFINES_SVH
`define OAS_DEFINES_SVH

// Prefix byte codes
`define OAS_PFX_OPSIZE 8'h66
`define OAS_PFX_ADSIZE 8'h67

// Size selector encoding: 0 = 16 bits, 1 = 32 bits
`define OAS_SZ16 1'h0
`define OAS_SZ32 1'h1

// Upper bounds of an expand-down segment
`define OAS_BOUND16 32'h0000ffff
`define OAS_BOUND32 32'hffffffff

// Mask applied to offsets formed at 16-bit address size
`define OAS_OFS16_MASK 32'h0000ffff

`endif

// File: oas_pkg.sv
package oas_pkg;

    typedef enum logic [2:0]
    {
        OAS_MODE_REAL = 3'h1,
        OAS_MODE_PROT = 3'h2,
        OAS_MODE_V86 = 3'h4
    } oas_mode_e;

    typedef enum logic [1:0]
    {
        OAS_ST_IDLE = 2'h1,
        OAS_ST_HOLD = 2'h2
    } oas_state_e;

endpackage

// File: oas_size_select_chk.sv
`timescale 1ns/10ps
`default_nettype none
module oas_size_select_chk
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic insn_valid,
    input wire logic insn_ready,
    input wire logic via_gate,
    input wire logic gate_is_32,
    input wire logic ss_big,
    input wire logic exec_done,
    input wire logic sel_valid,
    input wire logic op_size_32,
    input wire logic addr_size_32,
    input wire logic save_fmt_32,
    input wire logic stack_ptr_wide,
    input wire logic [31:0] eff_offset
);
    wire take = insn_ready && insn_valid;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    gate_size_a: assert property (take && via_gate |=> op_size_32 == $past(gate_is_32)) else $error("gate");
    save_fmt_a: assert property (sel_valid |-> save_fmt_32 == op_size_32) else $error("format");
    stack_ptr_a: assert property (take |=> stack_ptr_wide == $past(ss_big)) else $error("stack");
    ofs_16_a: assert property (sel_valid && !addr_size_32 |-> eff_offset[31:16] == 16'h0) else $error("ofs");
    hold_sizes_a: assert property (sel_valid && !exec_done |=> sel_valid && $stable({op_size_32, addr_size_32}))
        else $error("hold");
    release_a: assert property (sel_valid && exec_done |=> !sel_valid && insn_ready) else $error("release");
    take_a: assert property (take |=> sel_valid && !insn_ready) else $error("take");
    one_state_a: assert property (!(insn_ready && sel_valid)) else $error("state");
    cover property (take && via_gate);
    cover property (take && ss_big);
    cover property (sel_valid && exec_done);
endmodule
bind oas_size_select oas_size_select_chk chk_u (.*);
`default_nettype wire

// File: oas_exec_model.sv
`timescale 1ns/10ps
`default_nettype none
module oas_exec_model
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic sel_valid,
    input wire logic slow,
    output logic exec_done
);
    logic wait_r;
    wire busy = sel_valid && !exec_done;
    always_ff @(posedge clk or negedge rst_b)
        if (!rst_b)
            {exec_done, wait_r} <= 2'h0;
        else
            {exec_done, wait_r} <= {busy && wait_r == slow, busy && wait_r != slow};
endmodule
`default_nettype wire

// File: oas_size_select_tb.sv
`timescale 1ns/10ps
`default_nettype none
module oas_size_select_tb;
    logic clk = '0, rst_b = '0, insn_valid = '0, pfx_opsize = '0, pfx_adsize = '0, via_gate = '0, gate_is_32 = '0;
    logic stack_implicit = '0, system_management_mode = '0, cs_default_32 = '0, ss_big = '0, ds_big = '0, slow = '0;
    logic ds_expand_down = '0, v_r = '0, exec_done, insn_ready, sel_valid, op_size_32, addr_size_32, save_fmt_32;
    logic stack_use_wide, stack_ptr_wide, d, ad, op;
    logic [2:0] cpu_mode = 3'h1;
    logic [31:0] insn_word = '0, raw_offset = '0, s = 32'h00017596, sel_insn, eff_offset, ds_upper_bound;
    logic [100:0] q[$];
    wire [100:0] got = {sel_insn, op_size_32, addr_size_32, save_fmt_32, stack_use_wide, stack_ptr_wide, eff_offset,
        ds_upper_bound};
    int error_cnt = 0, n_compared = 0;
    oas_size_select dut_u (.*);
    oas_exec_model model_u (.*);
    initial forever #50 clk = ~clk;
    function automatic logic [31:0] lfsr(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic check(input logic [100:0] seen, input logic [100:0] exp);
        n_compared++;
        error_cnt += int'(seen !== exp);
        if (seen !== exp)
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
    endtask
    task automatic tally_and_finish();
        $display("Errors %0d of %0d", error_cnt, n_compared);
        if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk)
    begin
        v_r <= sel_valid;
        if (sel_valid === 1'h1 && v_r !== 1'h1)
            check(got, q.pop_front());
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst_b <= '1;
        repeat (300)
        begin
            do @(posedge clk); while (insn_ready !== 1'h1);
            repeat (5) s = lfsr(s);
            d = s[1:0] % 3 == 1 && !(s[2] && s[3]) && s[4];
            ad = d ^ s[6];
            op = s[7] && s[8] ? s[9] : d ^ s[5];
            {cpu_mode, system_management_mode, via_gate, slow} <= {3'(3'h1 << s[1:0] % 3), s[2] && s[3], s[7] && s[8], s[14]};
            {stack_implicit, ss_big, ds_big, ds_expand_down, gate_is_32, pfx_adsize, pfx_opsize, cs_default_32}
                <= {s[13:9], s[6:4]};
            {raw_offset, insn_word, insn_valid} <= {s, ~s, 1'h1};
            q.push_back({~s, op, ad, op, s[13] ? s[12] : ad, s[12], ad ? s : s & 32'h0000ffff,
                s[10] && s[11] ? 32'hffffffff : 32'h0000ffff});
            @(posedge clk);
            insn_valid <= '0;
        end
        repeat (10) @(posedge clk);
        tally_and_finish();
    end
    initial
    begin
        #1000000 error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
